// >>> design/timer_ch34_consts.vh
// Purpose: shared constants for the channel 3/4 capture/compare block
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: field positions refer to the mode register
//
// How it works
// - fast bit clear: output follows counter compare, trigger has no direct path
// - fast bit set: trigger edge acts as compare match within 3 cycles
// - fast bit only acts for output channels in either PWM mode
// - input channels pass a filtered input changing after N agreeing samples
// - filter codes 0 to 3 sample at clock rate, N of 1, 2, 4, 8
// - codes 4,5 sample at half rate N 6,8; codes 6,7 quarter rate N 6,8
// - codes 8 to 15 sample at one eighth, sixteenth or thirty-second rate
// - capture divider captures every 1, 2, 4 or 6 events
// - channel 4 direction: output, input four, input three, internal trigger
// - channel 3 has the same fields and behaviour as channel 4
// - channel 4 filter 15:12, divider 11:10, fast 10, direction 9:8
// - channel 3 mode 6:4, buffer 3, fast 2, filter 7:4, divider 3:2
// - channel 3 direction: output, input three, input four, internal trigger
// - compare buffer off writes active value; on copies at update event
`ifndef TIMER_CH34_CONSTS_VH
`define TIMER_CH34_CONSTS_VH

// register byte offsets
`define OFF_MODE 8'h00
`define OFF_ENABLE 8'h04
`define OFF_CH3_COMPARE 8'h08
`define OFF_CH4_COMPARE 8'h0C
`define OFF_CH3_CAPTURE 8'h10
`define OFF_CH4_CAPTURE 8'h14
`define OFF_STATUS 8'h18

// reset values
`define RST_MODE 16'h0000
`define RST_ENABLE 2'h0
`define RST_COMPARE 16'h0000

`define CH4_FILT_HI 15
`define CH4_FILT_LO 12
`define CH4_MODE_HI 14
`define CH4_MODE_LO 12
`define CH4_BUF_BIT 11
`define CH4_PSC_HI 11
`define CH4_PSC_LO 10
`define CH4_FAST_BIT 10
`define CH4_DIR_HI 9
`define CH4_DIR_LO 8

`define CH3_FILT_HI 7
`define CH3_FILT_LO 4
`define CH3_MODE_HI 6
`define CH3_MODE_LO 4
`define CH3_BUF_BIT 3
`define CH3_PSC_HI 3
`define CH3_PSC_LO 2
`define CH3_FAST_BIT 2
`define CH3_DIR_HI 1
`define CH3_DIR_LO 0

// direction select codes
`define DIR_OUTPUT 2'h0
`define DIR_ALT_A 2'h1
`define DIR_ALT_B 2'h2
`define DIR_TRIGGER 2'h3

// output modes
`define OM_FROZEN 3'h0
`define OM_SET 3'h1
`define OM_CLEAR 3'h2
`define OM_TOGGLE 3'h3
`define OM_FORCE_LOW 3'h4
`define OM_FORCE_HIGH 3'h5
`define OM_PWM1 3'h6
`define OM_PWM2 3'h7

// timing counts in clock cycles
`define FAST_TRIGGER_MAX_CYCLES 3
`define NORMAL_TRIGGER_MIN_CYCLES 5

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> design/input_filter.v
// Purpose: digital filter with selectable sampling rate and sample count
// Assumes: din synchronous to clk
// Notes: sampling enable comes from an internal divider
`timescale 1ns/1ps
`include "timer_ch34_consts.vh"

module input_filter #(
  parameter DIV_W = 5,
  parameter CNT_W = 4
) (
  input wire clk,
  input wire rst,
  input wire [3:0] code,
  input wire din,
  output reg dout
);

  // ==========================================================
  // code decode: {divide minus one, samples needed}
  // ==========================================================
  function [8:0] decode;
    input [3:0] c;
    begin
      case (c)
        4'h0: decode = {5'h00, 4'h1};
        4'h1: decode = {5'h00, 4'h2};
        4'h2: decode = {5'h00, 4'h4};
        4'h3: decode = {5'h00, 4'h8};
        4'h4: decode = {5'h01, 4'h6};
        4'h5: decode = {5'h01, 4'h8};
        4'h6: decode = {5'h03, 4'h6};
        4'h7: decode = {5'h03, 4'h8};
        4'h8: decode = {5'h07, 4'h6};
        4'h9: decode = {5'h07, 4'h8};
        4'hA: decode = {5'h0F, 4'h5};
        4'hB: decode = {5'h0F, 4'h6};
        4'hC: decode = {5'h0F, 4'h8};
        4'hD: decode = {5'h1F, 4'h5};
        4'hE: decode = {5'h1F, 4'h6};
        default: decode = {5'h1F, 4'h8};
      endcase
    end
  endfunction

  wire [8:0] cfg;
  wire [DIV_W-1:0] div_max;
  wire [CNT_W-1:0] need;
  wire sample_en;
  reg [DIV_W-1:0] div;
  reg [CNT_W-1:0] run;

  assign cfg = decode(code);
  assign div_max = cfg[8:4];
  assign need = cfg[3:0];
  assign sample_en = (div >= div_max);

  // ==========================================================
  // sampling divider and agreement counter
  // ==========================================================
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 5'h00;
      run <= 4'h0;
      dout <= 1'b0;
    end else begin
      if (sample_en) begin
        div <= 5'h00;
      end else begin
        div <= div + 5'h01;
      end
      if (code == 4'h0) begin
        dout <= din;
        run <= 4'h0;
      end else if (sample_en) begin
        if (din == dout) begin
          run <= 4'h0;
        end else if (run == need - 4'h1) begin
          dout <= din;
          run <= 4'h0;
        end else begin
          run <= run + 4'h1;
        end
      end
    end
  end

endmodule // input_filter

// >>> design/capture_divider.v
// Purpose: passes one capture out of every 1, 2, 4 or 6 edge events
// Assumes: event_in is a one-cycle pulse
// Notes: counter restarts while the channel is not capturing
`timescale 1ns/1ps
`include "timer_ch34_consts.vh"

module capture_divider (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire [1:0] code,
  input wire event_in,
  output reg capture
);

  function [2:0] last_count;
    input [1:0] c;
    begin
      case (c)
        2'h0: last_count = 3'h0;
        2'h1: last_count = 3'h1;
        2'h2: last_count = 3'h3;
        default: last_count = 3'h5;
      endcase
    end
  endfunction

  reg [2:0] count;

  // ==========================================================
  // event counter
  // ==========================================================
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 3'h0;
      capture <= 1'b0;
    end else if (!enable) begin
      count <= 3'h0;
      capture <= 1'b0;
    end else begin
      capture <= 1'b0;
      if (event_in) begin
        // every 1, 2, 4 or 6
        if (count >= last_count(code)) begin
          count <= 3'h0;
          capture <= 1'b1;
        end else begin
          count <= count + 3'h1;
        end
      end
    end
  end

endmodule // capture_divider

// >>> design/timer_ch34_mode_config.v
// Purpose: channel 3/4 mode configuration, compare outputs and filtered capture
// Assumes: counter, update event and trigger come from the surrounding timer
// Notes: registers reached over AXI4-Lite, one aligned word each
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "timer_ch34_consts.vh"

module timer_ch34_mode_config (
  input wire MCLK,
  input wire RESET,
  input wire AWVALID,
  output wire AWREADY,
  input wire [7:0] AWADDR,
  input wire WVALID,
  output wire WREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  output reg BVALID,
  input wire BREADY,
  output reg [1:0] BRESP,
  input wire ARVALID,
  output wire ARREADY,
  input wire [7:0] ARADDR,
  output reg RVALID,
  input wire RREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  input wire [15:0] COUNTER,
  input wire UPDATE_EVENT,
  input wire TIMER_INPUT_THREE,
  input wire TIMER_INPUT_FOUR,
  input wire INTERNAL_TRIGGER_INPUT,
  output reg CH3_COMPARE_OUTPUT,
  output reg CH4_COMPARE_OUTPUT
);

  // ==========================================================
  // helpers
  // ==========================================================
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // next reference level of one output channel
  function next_ref;
    input [2:0] mode;
    input cur;
    input [15:0] cnt;
    input [15:0] cmp;
    input fast_hold;
    reg match;
    begin
      match = (cnt == cmp);
      case (mode)
        `OM_FROZEN: next_ref = cur;
        `OM_SET: next_ref = match ? 1'b1 : cur;
        `OM_CLEAR: next_ref = match ? 1'b0 : cur;
        `OM_TOGGLE: next_ref = match ? ~cur : cur;
        `OM_FORCE_LOW: next_ref = 1'b0;
        `OM_FORCE_HIGH: next_ref = 1'b1;
        `OM_PWM1: next_ref = fast_hold ? 1'b0 : (cnt < cmp);
        `OM_PWM2: next_ref = fast_hold ? 1'b1 : ~(cnt < cmp);
        default: next_ref = cur;
      endcase
    end
  endfunction

  function is_pwm;
    input [2:0] mode;
    begin
      is_pwm = (mode == `OM_PWM1) || (mode == `OM_PWM2);
    end
  endfunction

  // ==========================================================
  // registers
  // ==========================================================
  reg [15:0] mode_reg;
  reg [1:0] enable_reg;
  reg [15:0] ch3_buffer;
  reg [15:0] ch4_buffer;
  reg [15:0] ch3_active;
  reg [15:0] ch4_active;
  reg [15:0] ch3_capture;
  reg [15:0] ch4_capture;
  reg ch3_ref;
  reg ch4_ref;
  reg ch3_fast_hold;
  reg ch4_fast_hold;
  reg trig_prev;
  reg ch3_filt_prev;
  reg ch4_filt_prev;

  wire [1:0] ch3_direction_select = mode_reg[`CH3_DIR_HI:`CH3_DIR_LO];
  wire [1:0] ch4_direction_select = mode_reg[`CH4_DIR_HI:`CH4_DIR_LO];
  wire ch3_is_out = (ch3_direction_select == `DIR_OUTPUT);
  wire ch4_is_out = (ch4_direction_select == `DIR_OUTPUT);
  wire [2:0] ch3_output_mode = ch3_is_out ? mode_reg[`CH3_MODE_HI:`CH3_MODE_LO] : 3'h0;
  wire [2:0] ch4_output_mode = ch4_is_out ? mode_reg[`CH4_MODE_HI:`CH4_MODE_LO] : 3'h0;
  wire ch3_compare_buffer_enable = ch3_is_out & mode_reg[`CH3_BUF_BIT];
  wire ch4_compare_buffer_enable = ch4_is_out & mode_reg[`CH4_BUF_BIT];
  wire ch3_fast_compare_enable = ch3_is_out & mode_reg[`CH3_FAST_BIT];
  wire ch4_fast_compare_enable = ch4_is_out & mode_reg[`CH4_FAST_BIT];
  wire [3:0] ch3_input_filter = ch3_is_out ? 4'h0 : mode_reg[`CH3_FILT_HI:`CH3_FILT_LO];
  wire [3:0] ch4_input_filter = ch4_is_out ? 4'h0 : mode_reg[`CH4_FILT_HI:`CH4_FILT_LO];
  wire [1:0] ch3_capture_divider = mode_reg[`CH3_PSC_HI:`CH3_PSC_LO];
  wire [1:0] ch4_capture_divider = mode_reg[`CH4_PSC_HI:`CH4_PSC_LO];
  wire ch3_channel_enable = enable_reg[0];
  wire ch4_channel_enable = enable_reg[1];
  wire ch3_filt;
  wire ch4_filt;

  function [31:0] rd_value;
    input [7:0] a;
    begin
      case (a)
        `OFF_MODE: rd_value = {16'h0000, mode_reg};
        `OFF_ENABLE: rd_value = {30'h0000_0000, enable_reg};
        `OFF_CH3_COMPARE: rd_value = {16'h0000, ch3_buffer};
        `OFF_CH4_COMPARE: rd_value = {16'h0000, ch4_buffer};
        `OFF_CH3_CAPTURE: rd_value = {16'h0000, ch3_capture};
        `OFF_CH4_CAPTURE: rd_value = {16'h0000, ch4_capture};
        `OFF_STATUS: rd_value = {28'h000_0000, ch4_ref, ch3_ref, ch4_filt, ch3_filt};
        default: rd_value = 32'h0000_0000;
      endcase
    end
  endfunction

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write = aw_held & w_held & ~BVALID;
  wire wr_hit = (aw_addr == `OFF_MODE) || (aw_addr == `OFF_ENABLE) ||
                (aw_addr == `OFF_CH3_COMPARE) || (aw_addr == `OFF_CH4_COMPARE);
  wire [31:0] wr_merged = merge(rd_value(aw_addr), w_data, w_strb);

  assign AWREADY = ~aw_held & ~BVALID;
  assign WREADY = ~w_held & ~BVALID;

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= `RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  wire rd_hit = (ARADDR <= `OFF_STATUS) && (ARADDR[1:0] == 2'h0);
  assign ARREADY = ~RVALID;

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= `RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA <= rd_value(ARADDR);
      RRESP <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ==========================================================
  // configuration and compare values
  // ==========================================================
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      mode_reg <= `RST_MODE;
      enable_reg <= `RST_ENABLE;
      ch3_buffer <= `RST_COMPARE;
      ch4_buffer <= `RST_COMPARE;
      ch3_active <= `RST_COMPARE;
      ch4_active <= `RST_COMPARE;
    end else begin
      if (UPDATE_EVENT && ch3_compare_buffer_enable) begin
        ch3_active <= ch3_buffer;
      end
      if (UPDATE_EVENT && ch4_compare_buffer_enable) begin
        ch4_active <= ch4_buffer;
      end
      if (do_write) begin
        case (aw_addr)
          `OFF_MODE: mode_reg <= wr_merged[15:0];
          `OFF_ENABLE: enable_reg <= wr_merged[1:0];
          `OFF_CH3_COMPARE: begin
            ch3_buffer <= wr_merged[15:0];
            if (!ch3_compare_buffer_enable) begin
              ch3_active <= wr_merged[15:0];
            end
          end
          `OFF_CH4_COMPARE: begin
            ch4_buffer <= wr_merged[15:0];
            if (!ch4_compare_buffer_enable) begin
              ch4_active <= wr_merged[15:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // compare outputs
  // ==========================================================
  wire trig_edge = INTERNAL_TRIGGER_INPUT & ~trig_prev;
  wire ch3_fast_on = ch3_fast_compare_enable & is_pwm(ch3_output_mode);
  wire ch4_fast_on = ch4_fast_compare_enable & is_pwm(ch4_output_mode);
  wire ch3_hold_now = ch3_fast_hold | (ch3_fast_on & trig_edge);
  wire ch4_hold_now = ch4_fast_hold | (ch4_fast_on & trig_edge);
  wire ch3_next = next_ref(ch3_output_mode, ch3_ref, COUNTER, ch3_active, ch3_hold_now);
  wire ch4_next = next_ref(ch4_output_mode, ch4_ref, COUNTER, ch4_active, ch4_hold_now);

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      trig_prev <= 1'b0;
      ch3_ref <= 1'b0;
      ch4_ref <= 1'b0;
      ch3_fast_hold <= 1'b0;
      ch4_fast_hold <= 1'b0;
      CH3_COMPARE_OUTPUT <= 1'b0;
      CH4_COMPARE_OUTPUT <= 1'b0;
    end else begin
      trig_prev <= INTERNAL_TRIGGER_INPUT;
      ch3_ref <= ch3_next;
      ch4_ref <= ch4_next;
      ch3_fast_hold <= ch3_hold_now & ch3_fast_on & ~UPDATE_EVENT &
                       (COUNTER != ch3_active);
      ch4_fast_hold <= ch4_hold_now & ch4_fast_on & ~UPDATE_EVENT &
                       (COUNTER != ch4_active);
      CH3_COMPARE_OUTPUT <= ch3_is_out & ch3_channel_enable & ch3_next;
      CH4_COMPARE_OUTPUT <= ch4_is_out & ch4_channel_enable & ch4_next;
    end
  end

  // ==========================================================
  // capture inputs
  // ==========================================================
  // channel 3 source select
  wire ch3_src = (ch3_direction_select == `DIR_ALT_A) ? TIMER_INPUT_THREE :
                 (ch3_direction_select == `DIR_ALT_B) ? TIMER_INPUT_FOUR :
                 INTERNAL_TRIGGER_INPUT;
  wire ch4_src = (ch4_direction_select == `DIR_ALT_A) ? TIMER_INPUT_FOUR :
                 (ch4_direction_select == `DIR_ALT_B) ? TIMER_INPUT_THREE :
                 INTERNAL_TRIGGER_INPUT;
  wire ch3_cap_pulse;
  wire ch4_cap_pulse;
  wire ch3_capturing = ~ch3_is_out & ch3_channel_enable;
  wire ch4_capturing = ~ch4_is_out & ch4_channel_enable;

  input_filter #(.DIV_W(5), .CNT_W(4)) u_ch3_filter (
    .clk(MCLK),
    .rst(RESET),
    .code(ch3_input_filter),
    .din(ch3_src),
    .dout(ch3_filt)
  );

  input_filter #(.DIV_W(5), .CNT_W(4)) u_ch4_filter (
    .clk(MCLK),
    .rst(RESET),
    .code(ch4_input_filter),
    .din(ch4_src),
    .dout(ch4_filt)
  );

  capture_divider u_ch3_divider (
    .clk(MCLK),
    .rst(RESET),
    .enable(ch3_capturing),
    .code(ch3_capture_divider),
    .event_in(ch3_filt & ~ch3_filt_prev),
    .capture(ch3_cap_pulse)
  );

  capture_divider u_ch4_divider (
    .clk(MCLK),
    .rst(RESET),
    .enable(ch4_capturing),
    .code(ch4_capture_divider),
    .event_in(ch4_filt & ~ch4_filt_prev),
    .capture(ch4_cap_pulse)
  );

  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      ch3_filt_prev <= 1'b0;
      ch4_filt_prev <= 1'b0;
      ch3_capture <= 16'h0000;
      ch4_capture <= 16'h0000;
    end else begin
      ch3_filt_prev <= ch3_filt;
      ch4_filt_prev <= ch4_filt;
      if (ch3_cap_pulse) begin
        ch3_capture <= COUNTER;
      end
      if (ch4_cap_pulse) begin
        ch4_capture <= COUNTER;
      end
    end
  end

endmodule // timer_ch34_mode_config

// >>> verification/timer_ch34_mode_config_asserts.sv
// Purpose: port checks for the channel 3/4 block
// Assumes: mode writes use full strobes, address and data together
// Notes: mirrors the mode register from bus traffic
`timescale 1ns/1ps
module timer_ch34_mode_config_asserts (
  input wire MCLK,
  input wire RESET,
  input wire AWVALID,
  input wire AWREADY,
  input wire [7:0] AWADDR,
  input wire WVALID,
  input wire WREADY,
  input wire [31:0] WDATA,
  input wire BVALID,
  input wire BREADY,
  input wire [1:0] BRESP,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] RDATA,
  input wire INTERNAL_TRIGGER_INPUT,
  input wire CH3_COMPARE_OUTPUT,
  input wire CH4_COMPARE_OUTPUT
);
  reg [15:0] mode;
  wire wr_both = AWVALID && AWREADY && WVALID && WREADY;
  // ==========================================================
  // mode mirror
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      mode <= 16'h0000;
    end else if (wr_both && AWADDR == 8'h00) begin
      mode <= WDATA[15:0];
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // ==========================================================
  // checks
  wr_answer_a: assert property (wr_both |-> ##[1:2] BVALID)
    else $error("write response late");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read response late");
  rd_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data not held");
  wr_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response not held");
  ar_block_a: assert property (RVALID |-> !ARREADY)
    else $error("read taken while busy");
  aw_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while busy");
  ch4_in_low_a: assert property ((mode[9:8] != 2'h0)[*4] |-> !CH4_COMPARE_OUTPUT)
    else $error("input channel 4 drives output");
  ch3_in_low_a: assert property ((mode[1:0] != 2'h0)[*4] |-> !CH3_COMPARE_OUTPUT)
    else $error("input channel 3 drives output");
  fast_match_a: assert property ($rose(INTERNAL_TRIGGER_INPUT) && mode[9:8] == 2'h0 &&
    mode[14:12] == 3'h6 && mode[10] |-> ##[1:3] !CH4_COMPARE_OUTPUT)
    else $error("fast trigger not applied");
endmodule // timer_ch34_mode_config_asserts

bind timer_ch34_mode_config timer_ch34_mode_config_asserts i_chk (.MCLK(MCLK), .RESET(RESET),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY),
  .WDATA(WDATA), .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
  .INTERNAL_TRIGGER_INPUT(INTERNAL_TRIGGER_INPUT), .CH3_COMPARE_OUTPUT(CH3_COMPARE_OUTPUT),
  .CH4_COMPARE_OUTPUT(CH4_COMPARE_OUTPUT));

// >>> verification/capture_source_model.sv
// Purpose: capture pins and trigger source in front of the block
// Assumes: levels requested by the bench
// Notes: slow adds one register stage; bit0 input three, bit1 input four, bit2 trigger
`timescale 1ns/1ps
module capture_source_model (
  input wire mclk,
  input wire [2:0] want,
  input wire slow,
  input wire trig_sel,
  output reg [2:0] pins = 3'b000
);
  reg [2:0] stage = 3'b000;
  always @(posedge mclk) begin
    stage <= want;
    pins[1:0] <= slow ? stage[1:0] : want[1:0];
    pins[2] <= trig_sel & (slow ? stage[2] : want[2]);
  end
endmodule // capture_source_model

// >>> verification/timer_ch34_mode_config_tb_top.sv
// Purpose: self-checking bench for the channel 3/4 block
// Assumes: registers at byte offsets 0x00 to 0x18
// Notes: one task per scenario
`timescale 1ns/1ps
module timer_ch34_mode_config_tb_top;
  reg mclk = 1'b0, reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, upd = 1'b0, slow = 1'b0, tsel = 1'b1;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0000_0000;
  reg [15:0] cnt = 16'h0000;
  reg [2:0] want = 3'b000;
  wire awready, wready, bvalid, arready, rvalid, o3, o4;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] pins;
  wire [1:0] outs = {o4, o3};
  integer n_fail = 0, tests_run = 0, cycles = 0;
  always #5 mclk = ~mclk;
  timer_ch34_mode_config i_dut (.MCLK(mclk), .RESET(reset), .AWVALID(awvalid),
    .AWREADY(awready), .AWADDR(awaddr), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
    .WSTRB(4'hF), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp), .ARVALID(arvalid),
    .ARREADY(arready), .ARADDR(araddr), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
    .RRESP(rresp), .COUNTER(cnt), .UPDATE_EVENT(upd), .TIMER_INPUT_THREE(pins[0]),
    .TIMER_INPUT_FOUR(pins[1]), .INTERNAL_TRIGGER_INPUT(pins[2]),
    .CH3_COMPARE_OUTPUT(o3), .CH4_COMPARE_OUTPUT(o4));
  capture_source_model i_src (.mclk(mclk), .want(want), .slow(slow), .trig_sel(tsel),
    .pins(pins));
  // ==========================================================
  // helpers
  task complete_run;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg ap, wp;
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      ap = 1'b1;
      wp = 1'b1;
      while (ap || wp) begin
        @(posedge mclk);
        if (ap && awready === 1'b1) begin
          awvalid <= 1'b0;
          ap = 1'b0;
        end
        if (wp && wready === 1'b1) begin
          wvalid <= 1'b0;
          wp = 1'b0;
        end
      end
      while (bvalid !== 1'b1) @(posedge mclk);
      chk({30'd0, bresp}, {30'd0, er});
      bready <= 1'b1;
      @(posedge mclk);
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      @(posedge mclk);
      while (arready !== 1'b1) @(posedge mclk);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge mclk);
      d = rdata;
      r = rresp;
      rready <= 1'b1;
      @(posedge mclk);
      rready <= 1'b0;
    end
  endtask
  task setup(input [15:0] m, input [1:0] e);
    wr(8'h04, 32'h0000_0000, 2'h0);
    wr(8'h00, {16'h0000, m}, 2'h0);
    wr(8'h04, {30'd0, e}, 2'h0);
  endtask
  // ==========================================================
  // scenarios
  task t_regs;
    reg [31:0] d;
    reg [1:0] r;
    begin
      rd(8'h00, d, r);
      chk(d, 32'h0000_0000);
      wr(8'h00, 32'h0000_A5C3, 2'h0);
      rd(8'h00, d, r);
      chk(d, 32'h0000_A5C3);
      rd(8'h1C, d, r);
      chk({30'd0, r}, 32'h0000_0002);
      wr(8'h10, 32'h0000_1234, 2'h2);
      wr(8'h00, 32'h0000_0000, 2'h0);
      $display("test regs done");
    end
  endtask
  task t_pwm(input integer c);
    begin
      setup(16'h0060 << (8 * c), 2'b01 << c);
      wr(8'h08 + 4 * c, 32'h0000_0010, 2'h0);
      cnt <= 16'h0005;
      cyc(3);
      chk(outs[c], 1);
      want <= 3'b100;
      cyc(4);
      chk(outs[c], 1);
      want <= 3'b000;
      cnt <= 16'h0020;
      cyc(3);
      chk(outs[c], 0);
      setup(16'h0068 << (8 * c), 2'b01 << c);
      cnt <= 16'h0005;
      wr(8'h08 + 4 * c, 32'h0000_0003, 2'h0);
      cyc(2);
      chk(outs[c], 1);
      upd <= 1'b1;
      cyc(1);
      upd <= 1'b0;
      cyc(3);
      chk(outs[c], 0);
      $display("test pwm done");
    end
  endtask
  task t_fast(input integer c);
    integer m;
    begin
      for (m = 6; m < 8; m = m + 1) begin
        setup(((m << 4) | 16'h0004) << (8 * c), 2'b01 << c);
        wr(8'h08 + 4 * c, 32'h0000_0010, 2'h0);
        cnt <= 16'h0005;
        cyc(3);
        chk(outs[c], m == 6);
        want <= 3'b100;
        cyc(4);
        chk(outs[c], m == 7);
        want <= 3'b000;
        upd <= 1'b1;
        cyc(1);
        upd <= 1'b0;
        cyc(3);
        chk(outs[c], m == 6);
      end
      setup(16'h0054 << (8 * c), 2'b01 << c);
      want <= 3'b100;
      cyc(4);
      chk(outs[c], 1);
      want <= 3'b000;
      setup(16'h0064 << (8 * c), 2'b01 << c);
      chk(outs[c], 1);
      $display("test fast done");
    end
  endtask
  function integer nval(input [3:0] f);
    case (f)
      0: nval = 1;
      1: nval = 2;
      2: nval = 4;
      4, 6, 8, 11, 14: nval = 6;
      10, 13: nval = 5;
      default: nval = 8;
    endcase
  endfunction
  function integer dval(input [3:0] f);
    dval = (f < 4) ? 1 : (f < 6) ? 2 : (f < 8) ? 4 : (f < 10) ? 8 : (f < 13) ? 16 : 32;
  endfunction
  task t_filter;
    integer f, n, dv;
    reg [31:0] d;
    reg [1:0] r;
    begin
      for (f = 0; f < 16; f = f + 1) begin
        n = nval(f);
        dv = dval(f);
        setup((f << 12) | 16'h0100, 2'b10);
        cyc(n * dv + dv + 4);
        if (n > 1) begin
          want <= 3'b010;
          cyc((n - 1) * dv);
          want <= 3'b000;
          cyc(n * dv + dv + 4);
          rd(8'h18, d, r);
          chk(d[1], 0);
        end
        want <= 3'b010;
        cyc(n * dv + dv + 4);
        rd(8'h18, d, r);
        chk(d[1], 1);
        want <= 3'b000;
      end
      $display("test filter done");
    end
  endtask
  task t_dirs;
    integer c, s, dir;
    reg [31:0] d;
    reg [1:0] r;
    begin
      for (c = 0; c < 2; c = c + 1) begin
        for (dir = 1; dir < 4; dir = dir + 1) begin
          s = (dir == 3) ? 2 : (dir == 1) ? c : 1 - c;
          setup(dir << (8 * c), 2'b01 << c);
          want <= ~(3'b001 << s);
          cyc(4);
          rd(8'h18, d, r);
          chk(d[c], 0);
          want <= 3'b001 << s;
          cyc(4);
          rd(8'h18, d, r);
          chk(d[c], 1);
          want <= 3'b000;
        end
      end
      $display("test dirs done");
    end
  endtask
  task t_div;
    integer p, k, i;
    reg [31:0] d;
    reg [1:0] r;
    begin
      slow <= 1'b1;
      for (p = 3; p >= 0; p = p - 1) begin
        k = (p == 3) ? 6 : (1 << p);
        setup((p << 10) | 16'h0100, 2'b10);
        for (i = 1; i <= k + 1; i = i + 1) begin
          cnt <= i * 16 + p;
          want <= 3'b010;
          cyc(4);
          want <= 3'b000;
          cyc(4);
        end
        rd(8'h14, d, r);
        chk(d, ((k == 1) ? 2 : k) * 16 + p);
      end
      slow <= 1'b0;
      $display("test divider done");
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    t_regs;
    t_pwm(0);
    t_pwm(1);
    t_fast(0);
    t_fast(1);
    t_filter;
    t_dirs;
    t_div;
    complete_run;
  end
endmodule // timer_ch34_mode_config_tb_top
